// [bfc_pkg.sv]
// Package for the block RAM FIFO controller: register map, control fields,
// reset values, depths and the flag carrier.
// Assumes one 40 MHz clock and a 32-bit AXI4-Lite register bus.
package bfc_pkg;

	localparam int          BFC_DATA_HALF   = 40;
	localparam int          BFC_DATA_FULL   = 80;
	localparam int          BFC_OFS_W       = 13;
	localparam int          BFC_MON_W       = 16;
	localparam int          BFC_DEPTH_TDP   = 1024;
	localparam int          BFC_DEPTH_SDP   = 512;
	localparam int          BFC_SYNC_STAGES = 2;

	// Register byte addresses
	localparam logic [7:0]  BFC_REG_CTRL    = 8'h00;
	localparam logic [7:0]  BFC_REG_AF_OFS  = 8'h04;
	localparam logic [7:0]  BFC_REG_AE_OFS  = 8'h08;
	localparam logic [7:0]  BFC_REG_STATUS  = 8'h0C;
	localparam logic [7:0]  BFC_REG_PTRS    = 8'h10;

	// Control register fields
	localparam int          BFC_CTRL_EN40K  = 0;
	localparam int          BFC_CTRL_ASYNC  = 1;
	localparam int          BFC_CTRL_SDP    = 2;
	localparam int          BFC_CTRL_DYNOFS = 3;
	localparam int          BFC_CTRL_W      = 4;

	localparam logic [3:0]  BFC_CTRL_RST    = 4'h1;
	localparam logic [12:0] BFC_AF_OFS_RST  = 13'h0004;
	localparam logic [12:0] BFC_AE_OFS_RST  = 13'h0004;

	localparam logic [1:0]  BFC_RESP_OKAY   = 2'h0;
	localparam logic [1:0]  BFC_RESP_SLVERR = 2'h2;

	typedef struct packed {
		logic full;
		logic almost_full;
		logic wr_err;
		logic empty;
		logic almost_empty;
		logic rd_err;
	} bfc_flags_t;

	function automatic logic [15:0] bfc_gray2bin(input logic [15:0] g);
		logic [15:0] b;
		b[15] = g[15];
		for (int i = 14; i >= 0; i--) begin
			b[i] = b[i + 1] ^ g[i];
		end
		return b;
	endfunction : bfc_gray2bin

endpackage : bfc_pkg

// [bfc_fifo_ctrl.sv]
// FIFO controller of a dual-port block RAM cell with an AXI4-Lite control slave.
// Assumes every input is synchronous to aclk and the mode bits change only while
// the FIFO is held in reset.
`timescale 1ns/100ps
module bfc_fifo_ctrl #(
	parameter int DEPTH = bfc_pkg::BFC_DEPTH_TDP
) (
	input  wire logic                              aclk,                // 40 MHz clock
	input  wire logic                              aresetn,             // Sync reset, low
	input  wire logic                              fifo_rst_n,          // FIFO reset, low
	input  wire logic                              push_en,             // Port B enable
	input  wire logic                              push_we,             // Port B write enable
	input  wire logic [bfc_pkg::BFC_DATA_HALF-1:0] write_port_data_in,  // Port B data in
	input  wire logic [bfc_pkg::BFC_DATA_HALF-1:0] write_port_bitmask,  // Port B bitmask
	input  wire logic [bfc_pkg::BFC_DATA_HALF-1:0] read_port_data_in,   // Port A data in (SIMPLE_DUAL_PORT_CONFIG high)
	input  wire logic [bfc_pkg::BFC_DATA_HALF-1:0] read_port_bitmask,   // Port A bitmask (SIMPLE_DUAL_PORT_CONFIG high)
	input  wire logic                              pop_en,              // Port A enable
	input  wire logic [bfc_pkg::BFC_OFS_W-1:0]     af_offset_in,        // Dynamic almost-full ofs
	input  wire logic [bfc_pkg::BFC_OFS_W-1:0]     ae_offset_in,        // Dynamic almost-empty ofs
	output logic      [bfc_pkg::BFC_DATA_HALF-1:0] read_port_data_out,  // Port A data out
	output logic      [bfc_pkg::BFC_DATA_HALF-1:0] write_port_data_out, // Port B data out (SIMPLE_DUAL_PORT_CONFIG high)
	output bfc_pkg::bfc_flags_t                    flags,               // FIFO status flags
	output logic      [bfc_pkg::BFC_MON_W-1:0]     read_address,        // Read pointer monitor
	output logic      [bfc_pkg::BFC_MON_W-1:0]     write_address,       // Write pointer monitor
	input  wire logic [7:0]                        s_axi_awaddr,        // AXI write address
	input  wire logic                              s_axi_awvalid,       // AXI
	output logic                                   s_axi_awready,       // AXI
	input  wire logic [31:0]                       s_axi_wdata,         // AXI write data
	input  wire logic [3:0]                        s_axi_wstrb,         // AXI byte strobes
	input  wire logic                              s_axi_wvalid,        // AXI
	output logic                                   s_axi_wready,        // AXI
	output logic      [1:0]                        s_axi_bresp,         // AXI
	output logic                                   s_axi_bvalid,        // AXI
	input  wire logic                              s_axi_bready,        // AXI
	input  wire logic [7:0]                        s_axi_araddr,        // AXI read address
	input  wire logic                              s_axi_arvalid,       // AXI
	output logic                                   s_axi_arready,       // AXI
	output logic      [31:0]                       s_axi_rdata,         // AXI read data
	output logic      [1:0]                        s_axi_rresp,         // AXI
	output logic                                   s_axi_rvalid,        // AXI
	input  wire logic                              s_axi_rready         // AXI
);
	import bfc_pkg::*;

	localparam int AW = $clog2(DEPTH);
	localparam int PW = AW + 1;

	logic [BFC_CTRL_W-1:0]    ctrl;
	logic [BFC_OFS_W-1:0]     af_ofs_reg;
	logic [BFC_OFS_W-1:0]     ae_ofs_reg;
	logic                     rst_s1;
	logic                     rst_s2;
	logic                     frst;
	logic [PW-1:0]            wptr;
	logic [PW-1:0]            rptr;
	logic [PW-1:0]            wgray;
	logic [PW-1:0]            rgray;
	logic [PW-1:0]            wg_s1;
	logic [PW-1:0]            wg_s2;
	logic [PW-1:0]            rg_s1;
	logic [PW-1:0]            rg_s2;
	logic [PW-1:0]            wptr_rd;
	logic [PW-1:0]            rptr_wr;
	logic [PW-1:0]            next_wptr;
	logic [PW-1:0]            next_rptr;
	logic [PW-1:0]            wr_fill;
	logic [PW-1:0]            rd_fill;
	logic [PW-1:0]            cap;
	logic [AW-1:0]            waddr;
	logic [AW-1:0]            raddr;
	logic [BFC_OFS_W:0]       af_ofs;
	logic [BFC_OFS_W:0]       ae_ofs;
	logic [BFC_DATA_FULL-1:0] mem [0:DEPTH-1];
	logic [BFC_DATA_FULL-1:0] wword;
	logic [BFC_DATA_FULL-1:0] wmask;
	logic                     fifo_on;
	logic                     simple_dual_port_config;
	logic                     push_req;
	logic                     pop_req;
	logic                     push_ok;
	logic                     pop_ok;
	logic                     aw_held;
	logic                     w_held;
	logic [7:0]               aw_addr;
	logic [31:0]              w_data;
	logic [3:0]               w_strb;
	logic [31:0]              rd_word;
	logic                     rd_hit;
	logic                     wr_hit;

	assign fifo_on = ctrl[BFC_CTRL_EN40K];
	assign simple_dual_port_config     = ctrl[BFC_CTRL_SDP];
	// Wide entries pair two halves, so the wide capacity scales with DEPTH
	assign cap     = simple_dual_port_config ? PW'(DEPTH * BFC_DEPTH_SDP / BFC_DEPTH_TDP) : PW'(DEPTH);

	// FIFO reset synchroniser
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rst_s1 <= 1'b0;
			rst_s2 <= 1'b0;
		end else begin
			rst_s1 <= fifo_rst_n;
			rst_s2 <= rst_s1;
		end
	end
	assign frst = !aresetn || !rst_s2;

	// Push and pop requests
	assign push_req  = fifo_on && push_en && push_we;
	assign pop_req   = fifo_on && pop_en;
	assign push_ok   = push_req && !flags.full;
	assign pop_ok    = pop_req && !flags.empty;
	assign next_wptr = wptr + PW'(1);
	assign next_rptr = rptr + PW'(1);

	// Both pointers run on the one clock; the mode picks how they are compared
	always_ff @(posedge aclk) begin
		if (frst) begin
			wptr  <= '0;
			wgray <= '0;
		end else if (push_ok) begin
			wptr  <= next_wptr;
			wgray <= next_wptr ^ (next_wptr >> 1);
		end
	end

	always_ff @(posedge aclk) begin
		if (frst) begin
			rptr  <= '0;
			rgray <= '0;
		end else if (pop_ok) begin
			rptr  <= next_rptr;
			rgray <= next_rptr ^ (next_rptr >> 1);
		end
	end

	// Two-flop pointer synchronisers for asynchronous mode
	always_ff @(posedge aclk) begin
		if (frst) begin
			wg_s1 <= '0;
			wg_s2 <= '0;
			rg_s1 <= '0;
			rg_s2 <= '0;
		end else begin
			wg_s1 <= wgray;
			wg_s2 <= wg_s1;
			rg_s1 <= rgray;
			rg_s2 <= rg_s1;
		end
	end

	always_comb begin
		if (ctrl[BFC_CTRL_ASYNC]) begin
			wptr_rd = PW'(bfc_gray2bin(16'(wg_s2)));
			rptr_wr = PW'(bfc_gray2bin(16'(rg_s2)));
		end else begin
			wptr_rd = wptr;
			rptr_wr = rptr;
		end
	end

	// Flags from pointers, combinational and not sticky
	assign wr_fill = wptr - rptr_wr;
	assign rd_fill = wptr_rd - rptr;
	assign af_ofs  = ctrl[BFC_CTRL_DYNOFS] ? {1'b0, af_offset_in} : {1'b0, af_ofs_reg};
	assign ae_ofs  = ctrl[BFC_CTRL_DYNOFS] ? {1'b0, ae_offset_in} : {1'b0, ae_ofs_reg};

	always_comb begin
		flags.full         = (wr_fill == cap);
		flags.almost_full  = ((BFC_OFS_W + 1)'(wr_fill) + af_ofs) >= (BFC_OFS_W + 1)'(cap);
		flags.wr_err       = push_req && (wr_fill == cap);
		flags.empty        = (rd_fill == '0);
		flags.almost_empty = (BFC_OFS_W + 1)'(rd_fill) <= ae_ofs;
		flags.rd_err       = pop_req && (rd_fill == '0);
	end

	// Storage addressed only by internal pointers
	assign waddr = simple_dual_port_config ? {1'b0, wptr[AW-2:0]} : wptr[AW-1:0];
	assign raddr = simple_dual_port_config ? {1'b0, rptr[AW-2:0]} : rptr[AW-1:0];

	always_comb begin
		if (simple_dual_port_config) begin
			wword = {write_port_data_in, read_port_data_in};
			wmask = {write_port_bitmask, read_port_bitmask};
		end else begin
			wword = {{BFC_DATA_HALF{1'b0}}, write_port_data_in};
			wmask = {{BFC_DATA_HALF{1'b0}}, write_port_bitmask};
		end
	end

	always_ff @(posedge aclk) begin
		if (push_ok && !frst) begin
			mem[waddr] <= (mem[waddr] & ~wmask) | (wword & wmask);
		end
	end

	always_ff @(posedge aclk) begin
		if (frst) begin
			read_port_data_out  <= '0;
			write_port_data_out <= '0;
		end else if (pop_ok) begin
			read_port_data_out  <= mem[raddr][BFC_DATA_HALF-1:0];
			write_port_data_out <= simple_dual_port_config ? mem[raddr][BFC_DATA_FULL-1:BFC_DATA_HALF] : '0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			read_address  <= '0;
			write_address <= '0;
		end else begin
			read_address  <= BFC_MON_W'(next_rptr & {PW{pop_ok}} | rptr & {PW{!pop_ok}});
			write_address <= BFC_MON_W'(next_wptr & {PW{push_ok}} | wptr & {PW{!push_ok}});
			if (frst) begin
				read_address  <= '0;
				write_address <= '0;
			end
		end
	end

	// AXI4-Lite write path: address and data taken in either order
	assign wr_hit = (aw_addr == BFC_REG_CTRL) || (aw_addr == BFC_REG_AF_OFS) ||
	                (aw_addr == BFC_REG_AE_OFS) || (aw_addr == BFC_REG_STATUS) ||
	                (aw_addr == BFC_REG_PTRS);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held       <= 1'b0;
			w_held        <= 1'b0;
			aw_addr       <= '0;
			w_data        <= '0;
			w_strb        <= '0;
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= BFC_RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held       <= 1'b1;
				aw_addr       <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held       <= 1'b1;
				w_data       <= s_axi_wdata;
				w_strb       <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (aw_held && w_held && !s_axi_bvalid) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_hit ? BFC_RESP_OKAY : BFC_RESP_SLVERR;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid  <= 1'b0;
				aw_held       <= 1'b0;
				w_held        <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl       <= BFC_CTRL_RST;
			af_ofs_reg <= BFC_AF_OFS_RST;
			ae_ofs_reg <= BFC_AE_OFS_RST;
		end else if (aw_held && w_held && !s_axi_bvalid) begin
			if (aw_addr == BFC_REG_CTRL && w_strb[0]) begin
				ctrl <= w_data[BFC_CTRL_W-1:0];
			end
			if (aw_addr == BFC_REG_AF_OFS) begin
				if (w_strb[0]) af_ofs_reg[7:0] <= w_data[7:0];
				if (w_strb[1]) af_ofs_reg[12:8] <= w_data[12:8];
			end
			if (aw_addr == BFC_REG_AE_OFS) begin
				if (w_strb[0]) ae_ofs_reg[7:0] <= w_data[7:0];
				if (w_strb[1]) ae_ofs_reg[12:8] <= w_data[12:8];
			end
		end
	end

	// AXI4-Lite read path
	always_comb begin
		rd_hit  = 1'b1;
		rd_word = '0;
		case (s_axi_araddr)
			BFC_REG_CTRL:   rd_word = 32'(ctrl);
			BFC_REG_AF_OFS: rd_word = 32'(af_ofs_reg);
			BFC_REG_AE_OFS: rd_word = 32'(ae_ofs_reg);
			BFC_REG_STATUS: rd_word = 32'(flags);
			BFC_REG_PTRS:   rd_word = {write_address, read_address};
			default:        rd_hit  = 1'b0;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= '0;
			s_axi_rresp   <= BFC_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rdata   <= rd_word;
			s_axi_rresp   <= rd_hit ? BFC_RESP_OKAY : BFC_RESP_SLVERR;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid  <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	// Checks
	default clocking cb @(posedge aclk); endclocking
	default disable iff (frst);

	sequence push_try_s;
		push_en && push_we && fifo_on;
	endsequence

	sequence pop_try_s;
		pop_en && fifo_on;
	endsequence

	full_exact_a: assert property ((wptr - rptr_wr) == cap |-> flags.full)
		else $error("full flag missing at capacity");
	rd_err_empty_a: assert property (pop_try_s and flags.empty |-> flags.rd_err)
		else $error("read error missing on empty pop");
	full_push_hold_a: assert property (push_try_s and flags.full |=> wptr == $past(wptr) && (flags.full || $past(pop_en)))
		else $error("push into full fifo moved write pointer");
	empty_pop_hold_a: assert property (pop_try_s and flags.empty |=> rptr == $past(rptr))
		else $error("pop from empty fifo moved read pointer");
	push_step_a: assert property (push_try_s and !flags.full |=> wptr == $past(wptr) + PW'(1))
		else $error("accepted push did not advance write pointer");
	err_release_a: assert property (!pop_en && !(push_en && push_we) |-> !flags.rd_err && !flags.wr_err)
		else $error("error flag held without a request");
	ptr_monitor_a: assert property (##1 1'b1 |-> write_address == BFC_MON_W'(wptr) && read_address == BFC_MON_W'(rptr))
		else $error("pointer monitor does not follow pointers");
	gray_sync_a: assert property (ctrl[BFC_CTRL_ASYNC] ##2 ctrl[BFC_CTRL_ASYNC] |-> wptr_rd == $past(wptr, 2))
		else $error("synchronised write pointer not two cycles late");
	no_small_cell_a: assert property (!fifo_on |=> $stable(wptr) && $stable(rptr))
		else $error("fifo moved while not in full-size mode");
	almost_empty_a: assert property ((BFC_OFS_W + 1)'(rd_fill) <= ae_ofs |-> flags.almost_empty)
		else $error("almost empty missing below offset");

endmodule : bfc_fifo_ctrl

// [bfc_user_model.sv]
// User logic beside the FIFO: a producer on port B and a consumer on port A.
// Assumes the bench raises do_push and do_pop just after rising edges of aclk.
`timescale 1ns/100ps
module bfc_user_model (
	input  wire logic        aclk,    // Clock
	input  wire logic        aresetn, // Reset, low
	input  wire logic        do_push, // Push request
	input  wire logic        do_pop,  // Pop request
	input  wire logic [79:0] word,    // Word to push
	output logic             push_en, // Port B enable
	output logic             push_we, // Port B write enable
	output logic             pop_en,  // Port A enable
	output logic      [39:0] data_hi, // Port B data
	output logic      [39:0] data_lo, // Port A data
	output logic      [39:0] mask_hi, // Port B mask
	output logic      [39:0] mask_lo  // Port A mask
);
	logic [79:0] last;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			last <= '0;
		end else if (do_push) begin
			last <= word;
		end
	end

	assign push_en = do_push;
	assign push_we = do_push;
	assign pop_en  = do_pop;
	// Released data lines show the inverse of the last word
	assign {data_hi, data_lo} = do_push ? word : ~last;
	assign mask_hi = {40{do_push}};
	assign mask_lo = {40{do_push}};
endmodule : bfc_user_model

// [bfc_fifo_ctrl_bench.sv]
// Self-checking bench for the FIFO controller: AXI4-Lite tasks plus user model.
// Assumes the default sync TRUE_DUAL_PORT_CONFIG mode after reset and a 16-entry depth.
`timescale 1ns/100ps
module bfc_fifo_ctrl_bench;
	import bfc_pkg::*;
	localparam int D = 16;
	logic        aclk, aresetn, fifo_rst_n, do_push, do_pop;
	logic        push_en, push_we, pop_en;
	logic [79:0] word, p;
	logic [39:0] dhi, dlo, mhi, mlo, rdo, wdo;
	logic [12:0] af_in, ae_in;
	bfc_flags_t  flags;
	logic [15:0] rd_addr, wr_addr;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp;
	logic        awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready;
	int          err_total, check_count, cycles;

	bfc_user_model model (.aclk(aclk), .aresetn(aresetn), .do_push(do_push), .do_pop(do_pop),
		.word(word), .push_en(push_en), .push_we(push_we), .pop_en(pop_en), .data_hi(dhi),
		.data_lo(dlo), .mask_hi(mhi), .mask_lo(mlo));

	bfc_fifo_ctrl #(.DEPTH(D)) dut (.aclk(aclk), .aresetn(aresetn), .fifo_rst_n(fifo_rst_n),
		.push_en(push_en), .push_we(push_we), .write_port_data_in(dhi), .write_port_bitmask(mhi),
		.read_port_data_in(dlo), .read_port_bitmask(mlo), .pop_en(pop_en),
		.af_offset_in(af_in), .ae_offset_in(ae_in), .read_port_data_out(rdo),
		.write_port_data_out(wdo), .flags(flags), .read_address(rd_addr), .write_address(wr_addr),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

	initial begin
		aclk = 1'b0;
		forever #12.5 aclk = ~aclk;
	end

	task automatic end_sim;
		$display("checks %0d mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : end_sim

	// Hang guard, well above the fewer than two hundred cycles the tests need
	always @(posedge aclk) begin
		cycles++;
		if (cycles == 5000) begin
			err_total++;
			end_sim();
		end
	end

	task automatic check(input string n, input logic [79:0] seen, input logic [79:0] exp);
		check_count++;
		if (seen !== exp) begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", n, exp, seen);
		end
	endtask : check

	task automatic done(input string n);
		$display("test %s finished", n);
	endtask : done

	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic ta, tw, tb;
		logic [1:0] r;
		tb = 1'b0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!tb) begin
			@(negedge aclk);
			ta = awvalid & awready;
			tw = wvalid & wready;
			tb = bvalid;
			r = bresp;
			@(posedge aclk);
			if (ta) awvalid <= 1'b0;
			if (tw) wvalid <= 1'b0;
		end
		bready <= 1'b0;
		check("bresp", 80'(r), 80'(er));
	endtask : axi_wr

	task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
		logic ta, tb;
		logic [1:0] r;
		logic [31:0] d;
		tb = 1'b0;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (!tb) begin
			@(negedge aclk);
			ta = arvalid & arready;
			tb = rvalid;
			r = rresp;
			d = rdata;
			@(posedge aclk);
			if (ta) arvalid <= 1'b0;
		end
		rready <= 1'b0;
		check("rresp", 80'(r), 80'(er));
		if (er === BFC_RESP_OKAY) check("rdata", 80'(d), 80'(ed));
	endtask : axi_rd

	// One FIFO cycle: requests go out at the edge, flags are looked at once settled
	task automatic cyc(input logic pu, input logic po, input logic [79:0] w);
		@(posedge aclk);
		do_push <= pu;
		do_pop <= po;
		word <= w;
		#1;
	endtask : cyc

	// Mode bits change only while the FIFO is held in reset
	task automatic mode(input logic [31:0] c);
		@(posedge aclk);
		fifo_rst_n <= 1'b0;
		repeat (2) @(posedge aclk);
		axi_wr(BFC_REG_CTRL, c, BFC_RESP_OKAY);
		@(posedge aclk);
		fifo_rst_n <= 1'b1;
		repeat (4) @(posedge aclk);
	endtask : mode

	function automatic logic [79:0] pat(input int i);
		return {~40'(i), 40'h5A_0000_0000 + 40'(i)};
	endfunction : pat

	initial begin
		{aresetn, fifo_rst_n, do_push, do_pop, word, p} = '0;
		{awaddr, araddr, wdata, awvalid, wvalid, bready, arvalid, rready} = '0;
		wstrb = 4'hF;
		{af_in, ae_in} = {13'h000D, 13'h0002};
		err_total = 0;
		check_count = 0;
		cycles = 0;
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		fifo_rst_n <= 1'b1;
		repeat (4) @(posedge aclk);
		axi_rd(BFC_REG_CTRL, 32'h0000_0001, BFC_RESP_OKAY);
		axi_rd(BFC_REG_AF_OFS, 32'h0000_0004, BFC_RESP_OKAY);
		axi_rd(BFC_REG_AE_OFS, 32'h0000_0004, BFC_RESP_OKAY);
		axi_rd(BFC_REG_STATUS, 32'h0000_0006, BFC_RESP_OKAY);
		axi_rd(BFC_REG_PTRS, 32'h0000_0000, BFC_RESP_OKAY);
		axi_rd(8'h14, 32'h0000_0000, BFC_RESP_SLVERR);
		axi_wr(BFC_REG_AF_OFS, 32'h0000_FFFF, BFC_RESP_OKAY);
		axi_rd(BFC_REG_AF_OFS, 32'h0000_1FFF, BFC_RESP_OKAY);
		axi_wr(BFC_REG_AF_OFS, 32'h0000_0004, BFC_RESP_OKAY);
		axi_wr(BFC_REG_STATUS, 32'hFFFF_FFFF, BFC_RESP_OKAY);
		axi_rd(BFC_REG_STATUS, 32'h0000_0006, BFC_RESP_OKAY);
		done("registers");
		cyc(1'b0, 1'b1, '0);
		check("rd_err", flags.rd_err, 1'b1);
		cyc(1'b0, 1'b0, '0);
		check("rd_err", flags.rd_err, 1'b0);
		check("read_address", 80'(rd_addr), 80'h0);
		done("empty pop");
		for (int i = 0; i <= D; i++) begin
			cyc(1'b1, 1'b0, pat(i));
			check("write_address", 80'(wr_addr), 80'(i));
			check("empty", flags.empty, i == 0);
			check("almost_full", flags.almost_full, i + 4 >= D);
			check("full", flags.full, i == D);
			check("wr_err", flags.wr_err, i == D);
		end
		cyc(1'b0, 1'b0, '0);
		check("wr_err", flags.wr_err, 1'b0);
		check("write_address", 80'(wr_addr), 80'(D));
		axi_rd(BFC_REG_PTRS, {16'(D), 16'h0000}, BFC_RESP_OKAY);
		done("fill");
		for (int i = 0; i <= D; i++) begin
			cyc(1'b0, i < D, '0);
			p = pat(i - 1);
			if (i > 0) check("pop data", 80'(rdo), 80'(p[79:40]));
			check("almost_empty", flags.almost_empty, D - i <= 4);
			check("empty", flags.empty, i == D);
			check("read_address", 80'(rd_addr), 80'(i));
		end
		done("drain");
		mode(32'h0000_0000);
		cyc(1'b1, 1'b0, pat(1));
		cyc(1'b0, 1'b0, '0);
		check("write_address", 80'(wr_addr), 80'h0);
		done("half size");
		mode(32'h0000_0005);
		p = pat(7);
		cyc(1'b1, 1'b0, p);
		cyc(1'b0, 1'b1, '0);
		cyc(1'b0, 1'b0, '0);
		check("pop low", 80'(rdo), 80'(p[39:0]));
		check("pop high", 80'(wdo), 80'(p[79:40]));
		done("wide");
		mode(32'h0000_0003);
		cyc(1'b1, 1'b0, pat(2));
		cyc(1'b0, 1'b0, '0);
		check("write_address", 80'(wr_addr), 80'h1);
		check("empty", flags.empty, 1'b1);
		repeat (3) cyc(1'b0, 1'b0, '0);
		check("empty", flags.empty, 1'b0);
		done("async");
		// Run-time offsets: fill 3 with full offset 13 and empty offset 2
		mode(32'h0000_0009);
		repeat (3) cyc(1'b1, 1'b0, pat(3));
		cyc(1'b0, 1'b0, '0);
		check("almost_empty", flags.almost_empty, 1'b0);
		check("almost_full", flags.almost_full, 1'b1);
		@(posedge aclk);
		ae_in <= 13'h0003;
		#1;
		check("almost_empty", flags.almost_empty, 1'b1);
		done("dynamic offsets");
		end_sim();
	end
endmodule : bfc_fifo_ctrl_bench
